// ---- hw/ldfs_top.v ----
// led driver fault supervisor: enable, timers, fault table, flags, bus
// Summary of operation
// RULE1: gate drive is off while enable is low.
// RULE2: led current reference ramps by a limited step per oscillator period.
// RULE3: host keeps its pwm period shorter than the sleep delay.
// RULE4: enable low past the sleep delay puts everything into sleep.
// RULE5: sleep delay is counted in oscillator periods.
// RULE6: tied oscillator pin selects the default rate, else divider or clock.
// RULE7: host keeps an external clock within the supported range.
// RULE8: phased clock output runs at the oscillator rate, delayed.
// RULE9: any fault releases one or both flags until removed.
// RULE10: flags pull low when inactive and float when active.
// RULE11: disabling faults force the gate low; warnings only flag.
// RULE12: critical faults latch; cleared only by reset or sleep.
// RULE13: non-latched faults restore the gate once the cause leaves.
// RULE14: a flag held low from outside cancels the matching disable.
// RULE15: fault detection is blanked after start-up and enable pulses.
// RULE16: open led and undervoltages bypass blanking.
// RULE17: supply undervoltage has hysteresis, gate low, both flags float.
// RULE18: regulator undervoltage has hysteresis, gate low, both flags float.
// RULE19: overtemperature floats only the general flag, with hysteresis.
// RULE20: overtemperature keeps being evaluated so the flag recovers.
// RULE21: open led disables for a retry time, then drive retries.
// RULE22: output short needs shorted led and undercurrent together.
// RULE23: blanking restarts on every enable rise, blocks blankable latching.
`timescale 1ns/1ns
`default_nettype none
`include "ldfs_map.vh"
module ldfs_top #(
	parameter SLEEP_PERIODS = `LDFS_SLEEP_PERIODS,
	parameter BLANK_PERIODS = `LDFS_BLANK_PERIODS,
	parameter RETRY_PERIODS = `LDFS_RETRY_PERIODS,
	parameter CW = 16
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	input wire enable_in,
	input wire osc_pin_tied,
	input wire osc_setting_pin,
	input wire supply_below_off,
	input wire supply_above_on,
	input wire reg_below_off,
	input wire reg_above_on,
	input wire temp_above_threshold,
	input wire temp_below_recovery,
	input wire open_led_detect,
	input wire shorted_led_detect,
	input wire undercurrent_detect,
	input wire sense_overcurrent_detect,
	input wire sense_neg_overcurrent_detect,
	input wire shorted_string_detect,
	input wire critical_fault_flag_i,
	output wire critical_fault_flag_o,
	output reg critical_fault_flag_oe,
	input wire general_fault_flag_i,
	output wire general_fault_flag_o,
	output reg general_fault_flag_oe,
	output reg gate_drive_out,
	output reg [7:0] led_current_ref,
	output reg sleep_out,
	output wire phased_clock_out
);
	localparam [CW-1:0] SLEEP_N = SLEEP_PERIODS;
	localparam [CW-1:0] BLANK_N = BLANK_PERIODS;
	localparam [CW-1:0] RETRY_N = RETRY_PERIODS;
	localparam [CW-1:0] CONE = 1;

	// set/clear state with the set taking priority
	function hyst;
		input cur;
		input set;
		input clr;
		begin
			hyst = set | (cur & ~clr);
		end
	endfunction

	// saturating period counter
	function [CW-1:0] bump;
		input [CW-1:0] c;
		begin
			bump = (c == {CW{1'b1}}) ? c : c + CONE;
		end
	endfunction

	// bus slave
	reg [31:0] ctrl_q;
	reg [15:0] oscdiv_q;
	reg [7:0] ramp_q;
	reg wr_pend_q;
	reg [3:0] wr_ofs_q;
	wire [31:0] status_w;
	wire take = hsel & hready & htrans[1];
	wire [3:0] ofs = haddr[3:0];
	wire mapped = (haddr[31:4] == 28'h000_0000);

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_ofs_q <= 4'h0;
			hrdata <= 32'h0000_0000;
		end else begin
			wr_pend_q <= take & hwrite & mapped;
			wr_ofs_q <= ofs;
			if (take & ~hwrite) begin
				if (!mapped)
					hrdata <= 32'h0000_0000;
				else begin
					case (ofs)
					`LDFS_CTRL_OFS: hrdata <= ctrl_q;
					`LDFS_OSCDIV_OFS: hrdata <= {16'h0000, oscdiv_q};
					`LDFS_STATUS_OFS: hrdata <= status_w;
					`LDFS_RAMP_OFS: hrdata <= {24'h00_0000, ramp_q};
					default: hrdata <= 32'h0000_0000;
					endcase
				end
			end
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= `LDFS_CTRL_RST;
			oscdiv_q <= `LDFS_OSC_DEFAULT_DIV;
			ramp_q <= `LDFS_RAMP_RST;
		end else if (wr_pend_q) begin
			case (wr_ofs_q)
			`LDFS_CTRL_OFS: ctrl_q <= hwdata;
			`LDFS_OSCDIV_OFS: oscdiv_q <= hwdata[15:0];
			`LDFS_RAMP_OFS: ramp_q <= hwdata[7:0];
			default: ctrl_q <= ctrl_q;
			endcase
		end
	end

	// oscillator: tied pin forces the internal default rate
	wire tick;
	ldfs_osc #(
		.W(16)
	) u_osc (
		.hclk(hclk),
		.hresetn(hresetn),
		.int_sel(osc_pin_tied), // RULE6
		.ext_sel(ctrl_q[`LDFS_CTRL_EXT_BIT]),
		.res_div(oscdiv_q),
		.phase(ctrl_q[`LDFS_CTRL_PH_MSB:`LDFS_CTRL_PH_LSB]),
		.osc_setting_pin(osc_setting_pin),
		.tick(tick),
		.phased_clock_out(phased_clock_out)
	);

	// supply, regulator and temperature states with hysteresis
	reg supply_uv_q;
	reg reg_uv_q;
	reg overtemp_q;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			supply_uv_q <= 1'b1;
			reg_uv_q <= 1'b1;
			overtemp_q <= 1'b0;
		end else begin
			supply_uv_q <= hyst(supply_uv_q, supply_below_off,
				supply_above_on); // RULE17
			reg_uv_q <= hyst(reg_uv_q, reg_below_off, reg_above_on); // RULE18
			overtemp_q <= hyst(overtemp_q, temp_above_threshold,
				temp_below_recovery); // RULE19 RULE20
		end
	end
	wire uv = supply_uv_q | reg_uv_q;

	// enable edge, sleep timer
	reg en_q;
	reg [CW-1:0] sleep_cnt_q;
	wire en_rise = enable_in & ~en_q;
	wire sleep_hit = (sleep_cnt_q >= SLEEP_N);
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			en_q <= 1'b0;
			sleep_cnt_q <= {CW{1'b0}};
			sleep_out <= 1'b0;
		end else begin
			en_q <= enable_in;
			if (enable_in) begin
				sleep_cnt_q <= {CW{1'b0}};
				sleep_out <= 1'b0;
			end else begin
				if (tick)
					sleep_cnt_q <= bump(sleep_cnt_q); // RULE5
				if (sleep_hit)
					sleep_out <= 1'b1; // RULE4
			end
		end
	end

	// blanking after start-up, uv recovery and each enable rise
	reg [CW-1:0] blank_cnt_q;
	reg uv_q;
	wire uv_fall = uv_q & ~uv;
	wire blank_active = (blank_cnt_q < BLANK_N);
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			blank_cnt_q <= {CW{1'b0}};
			uv_q <= 1'b1;
		end else begin
			uv_q <= uv;
			if (en_rise | uv_fall)
				blank_cnt_q <= {CW{1'b0}}; // RULE23
			else if (tick & blank_active)
				blank_cnt_q <= blank_cnt_q + CONE; // RULE15
		end
	end

	// detection is live only while running
	wire live = enable_in & ~sleep_out & ~uv;
	wire det = live & ~blank_active & ~en_rise & ~uv_fall; // RULE15 RULE23
	wire short_led_b = det & shorted_led_detect;
	wire under_b = det & undercurrent_detect;
	wire out_short = short_led_b & under_b; // RULE22
	wire crit_set = out_short | (det & (sense_overcurrent_detect |
		sense_neg_overcurrent_detect | shorted_string_detect));

	// critical latch: cleared by reset or sleep only
	reg crit_latch_q;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			crit_latch_q <= 1'b0;
		else
			crit_latch_q <= hyst(crit_latch_q, crit_set, sleep_out); // RULE12
	end

	// open led: immediate, held for the retry time
	reg open_q;
	reg [CW-1:0] retry_cnt_q;
	wire open_set = live & open_led_detect; // RULE16
	wire retry_done = (retry_cnt_q >= RETRY_N);
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			open_q <= 1'b0;
			retry_cnt_q <= {CW{1'b0}};
		end else if (open_q) begin
			if (retry_done | sleep_out) begin
				open_q <= 1'b0; // RULE21
				retry_cnt_q <= {CW{1'b0}};
			end else if (tick) begin
				retry_cnt_q <= bump(retry_cnt_q);
			end
		end else begin
			open_q <= open_set;
			retry_cnt_q <= {CW{1'b0}};
		end
	end

	// flag release and external overrides
	wire crit_rel = uv | crit_latch_q; // RULE9 RULE12 RULE17 RULE18
	wire gen_rel = uv | overtemp_q | open_q | short_led_b |
		under_b; // RULE9 RULE19
	// only a released flag can be held low from outside
	wire crit_ovr = crit_latch_q & ~critical_fault_flag_oe &
		~critical_fault_flag_i; // RULE14
	wire gen_ovr = open_q & ~general_fault_flag_oe &
		~general_fault_flag_i; // RULE14
	wire disable_w = uv | (crit_latch_q & ~crit_ovr) |
		(open_q & ~gen_ovr); // RULE11 RULE13

	assign critical_fault_flag_o = 1'b0;
	assign general_fault_flag_o = 1'b0;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			critical_fault_flag_oe <= 1'b1;
			general_fault_flag_oe <= 1'b1;
			gate_drive_out <= 1'b0;
		end else begin
			critical_fault_flag_oe <= ~crit_rel; // RULE10
			general_fault_flag_oe <= ~gen_rel; // RULE10
			gate_drive_out <= enable_in & ~sleep_out & ~disable_w; // RULE1
		end
	end

	// current reference ramp, one step per oscillator period
	wire [8:0] up = {1'b0, led_current_ref} + {1'b0, ramp_q};
	wire [8:0] dn = {1'b0, led_current_ref} - {1'b0, ramp_q};
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			led_current_ref <= `LDFS_LEVEL_MIN;
		else if (tick) begin
			if (gate_drive_out)
				led_current_ref <= up[8] ? `LDFS_LEVEL_MAX : up[7:0]; // RULE2
			else
				led_current_ref <= dn[8] ? `LDFS_LEVEL_MIN : dn[7:0]; // RULE2
		end
	end

	assign status_w = {8'h00, led_current_ref, 2'b00, gen_ovr, crit_ovr,
		gen_rel, crit_rel, gate_drive_out, blank_active, sleep_out,
		crit_latch_q, under_b, short_led_b, open_q, overtemp_q,
		reg_uv_q, supply_uv_q};
endmodule // ldfs_top
`default_nettype wire

// ---- common/ldfs_map.vh ----
// register map, field positions and timing counts of the fault supervisor
`ifndef LDFS_MAP_VH
`define LDFS_MAP_VH
// register byte offsets
`define LDFS_CTRL_OFS 4'h0
`define LDFS_OSCDIV_OFS 4'h4
`define LDFS_STATUS_OFS 4'h8
`define LDFS_RAMP_OFS 4'hc
// control register fields
`define LDFS_CTRL_EXT_BIT 0
`define LDFS_CTRL_PH_LSB 8
`define LDFS_CTRL_PH_MSB 23
`define LDFS_CTRL_RST 32'h0000_0000
// status register fields
`define LDFS_ST_SUPPLY_UV 0
`define LDFS_ST_REG_UV 1
`define LDFS_ST_OVERTEMP 2
`define LDFS_ST_OPEN 3
`define LDFS_ST_SHORT_LED 4
`define LDFS_ST_UNDER 5
`define LDFS_ST_CRIT_LATCH 6
`define LDFS_ST_SLEEP 7
`define LDFS_ST_BLANK 8
`define LDFS_ST_GATE 9
`define LDFS_ST_CRIT_REL 10
`define LDFS_ST_GEN_REL 11
`define LDFS_ST_CRIT_OVR 12
`define LDFS_ST_GEN_OVR 13
`define LDFS_ST_LEVEL_LSB 16
// timing: hclk and default oscillator rates in kHz
`define LDFS_HCLK_KHZ 10000
`define LDFS_OSC_DEFAULT_KHZ 350
`define LDFS_OSC_DEFAULT_DIV (`LDFS_HCLK_KHZ / `LDFS_OSC_DEFAULT_KHZ)
// counts in oscillator periods
`define LDFS_SLEEP_PERIODS 32768
`define LDFS_BLANK_PERIODS 1024
`define LDFS_RETRY_PERIODS 32768
// ramp defaults
`define LDFS_RAMP_RST 8'h04
`define LDFS_LEVEL_MAX 8'hff
`define LDFS_LEVEL_MIN 8'h00
`endif

// ---- hw/ldfs_osc.v ----
// oscillator period tick and phase-delayed clock output
`timescale 1ns/1ns
`default_nettype none
`include "ldfs_map.vh"
module ldfs_osc #(
	parameter W = 16
) (
	input wire hclk,
	input wire hresetn,
	input wire int_sel,
	input wire ext_sel,
	input wire [W-1:0] res_div,
	input wire [W-1:0] phase,
	input wire osc_setting_pin,
	output reg tick,
	output reg phased_clock_out
);
	localparam [W-1:0] DEF_DIV = `LDFS_OSC_DEFAULT_DIV;
	localparam [W-1:0] ONE = 1;
	reg ext_q;
	reg [W-1:0] cnt_q;
	reg [W-1:0] period_q;
	wire ext_edge = osc_setting_pin & ~ext_q;
	wire use_ext = ext_sel & ~int_sel;
	wire [W-1:0] div = int_sel ? DEF_DIV :
		((res_div < ONE) ? ONE : res_div);
	wire wrap = use_ext ? ext_edge : (cnt_q >= div - ONE);
	wire [W-1:0] pos = (cnt_q >= phase) ? cnt_q - phase :
		cnt_q + period_q - phase;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_q <= 1'b0;
			cnt_q <= {W{1'b0}};
			period_q <= DEF_DIV;
			tick <= 1'b0;
			phased_clock_out <= 1'b0;
		end else begin
			ext_q <= osc_setting_pin;
			tick <= wrap;
			if (wrap) begin
				cnt_q <= {W{1'b0}};
				period_q <= use_ext ? cnt_q + ONE : div;
			end else if (cnt_q != {W{1'b1}}) begin
				cnt_q <= cnt_q + ONE;
			end
			// high for the first half period, shifted by phase cycles
			phased_clock_out <= pos < (period_q >> 1); // RULE8
		end
	end
endmodule // ldfs_osc
`default_nettype wire

// ---- verif/ldfs_props.sv ----
// port-level timing checker of the fault supervisor
`timescale 1ns/1ns
`default_nettype none
module ldfs_props #(
	parameter SLEEP_PERIODS = 64
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic enable_in,
	input wire logic supply_below_off,
	input wire logic reg_below_off,
	input wire logic temp_above_threshold,
	input wire logic open_led_detect,
	input wire logic general_fault_flag_i,
	input wire logic critical_fault_flag_o,
	input wire logic general_fault_flag_o,
	input wire logic critical_fault_flag_oe,
	input wire logic general_fault_flag_oe,
	input wire logic gate_drive_out,
	input wire logic sleep_out
);
	localparam int OP = 28;
	logic [19:0] low_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			low_q <= 20'h0;
		else if (enable_in)
			low_q <= 20'h0;
		else if (low_q != 20'hfffff)
			low_q <= low_q + 20'h1;
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence uv_s;
		enable_in && !sleep_out && (supply_below_off || reg_below_off);
	endsequence
	sequence crit_s;
		$fell(critical_fault_flag_oe) && $past(gate_drive_out) && enable_in
			&& !supply_below_off && !reg_below_off;
	endsequence
	gate_off_a: assert property (!enable_in |=> !gate_drive_out)
		else $error("gate on while enable low");
	uv_off_a: assert property (uv_s |-> ##2 !gate_drive_out
		&& !critical_fault_flag_oe && !general_fault_flag_oe)
		else $error("undervoltage not handled");
	ot_flag_a: assert property (temp_above_threshold && enable_in
		&& !sleep_out |-> ##2 !general_fault_flag_oe)
		else $error("overtemperature flag missing");
	open_gate_a: assert property ($rose(open_led_detect)
		&& enable_in && !sleep_out && general_fault_flag_oe
		&& !general_fault_flag_i |-> ##[1:2] !gate_drive_out)
		else $error("open led kept gate on");
	pin_low_a: assert property (!critical_fault_flag_o
		&& !general_fault_flag_o)
		else $error("flag pin drives high");
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus response not okay");
	crit_latch_a: assert property (crit_s |=>
		!critical_fault_flag_oe [*8])
		else $error("critical latch dropped");
	blank_hold_a: assert property ($rose(enable_in)
		&& critical_fault_flag_oe |=> critical_fault_flag_oe [*8])
		else $error("critical flag in blanking");
	sleep_on_a: assert property (low_q > SLEEP_PERIODS * OP + OP
		|-> sleep_out)
		else $error("sleep not entered");
	sleep_early_a: assert property (sleep_out && !enable_in
		|-> low_q >= (SLEEP_PERIODS - 1) * OP)
		else $error("sleep entered early");
endmodule // ldfs_props
bind ldfs_top ldfs_props #(.SLEEP_PERIODS(SLEEP_PERIODS)) i_ldfs_props (.*);
`default_nettype wire

// ---- verif/ldfs_host.sv ----
// host model: flag pull-ups and the override hold
`timescale 1ns/1ns
`default_nettype none
module ldfs_host (
	input wire logic crit_oe,
	input wire logic crit_o,
	input wire logic gen_oe,
	input wire logic gen_o,
	input wire logic hold_crit,
	input wire logic hold_gen,
	output logic crit_pin,
	output logic gen_pin
);
	// a released flag floats to the pull-up unless held low
	assign crit_pin = crit_oe ? crit_o : !hold_crit;
	assign gen_pin = gen_oe ? gen_o : !hold_gen;
endmodule // ldfs_host
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench of the fault supervisor
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	localparam int SP = 64;
	logic hclk = 0, hresetn = 0, en = 0, hold_c = 0, hold_g = 0, hwrite = 0;
	logic tied = 1, oscp = 0;
	logic [1:0] htrans = 0, tmp = 0;
	logic [31:0] haddr = 0, hwdata = 0, rd;
	// reg on, reg off, supply on, supply off
	logic [3:0] uv = 4'ha;
	logic [5:0] f = 0;
	wire hrdy, hresp, c_o, c_oe, g_o, g_oe, c_pin, g_pin, gate, slp, ph;
	wire [31:0] hrdata;
	wire [7:0] cur;
	int errors = 0, num_checks = 0, cyc = 0;
	ldfs_top #(.SLEEP_PERIODS(SP), .BLANK_PERIODS(8), .RETRY_PERIODS(32))
		i_ldfs_top (.hclk(hclk), .hresetn(hresetn), .hsel(1'h1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp),
		.hrdata(hrdata), .enable_in(en), .osc_pin_tied(tied),
		.osc_setting_pin(oscp), .supply_below_off(uv[0]),
		.supply_above_on(uv[1]), .reg_below_off(uv[2]),
		.reg_above_on(uv[3]), .temp_above_threshold(tmp[0]),
		.temp_below_recovery(tmp[1]), .open_led_detect(f[0]),
		.shorted_led_detect(f[1]), .undercurrent_detect(f[2]),
		.sense_overcurrent_detect(f[3]),
		.sense_neg_overcurrent_detect(f[4]), .shorted_string_detect(f[5]),
		.critical_fault_flag_i(c_pin), .critical_fault_flag_o(c_o),
		.critical_fault_flag_oe(c_oe), .general_fault_flag_i(g_pin),
		.general_fault_flag_o(g_o), .general_fault_flag_oe(g_oe),
		.gate_drive_out(gate), .led_current_ref(cur), .sleep_out(slp),
		.phased_clock_out(ph));
	ldfs_host i_ldfs_host (.crit_oe(c_oe), .crit_o(c_o), .gen_oe(g_oe),
		.gen_o(g_o), .hold_crit(hold_c), .hold_gen(hold_g),
		.crit_pin(c_pin), .gen_pin(g_pin));
	initial begin
		forever #50 hclk = ~hclk;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task automatic tally_and_finish;
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc++;
		if (cyc % 12 == 0)
			oscp <= ~oscp;
		if (cyc == 20000) begin
			errors++;
			tally_and_finish();
		end
	end
	// single word transfer, waits for hready in both phases
	task automatic bus(input logic wr, input logic [31:0] a, d,
		output logic [31:0] q);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		@(posedge hclk);
		while (hrdy !== 1'h1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hrdy !== 1'h1) @(posedge hclk);
		q = hrdata;
	endtask
	task automatic t_regs;
		logic [31:0] a[5] = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h10};
		logic [31:0] e[5] = '{32'h0, 32'h1c, 32'h100, 32'h4, 32'h0};
		for (int i = 0; i < 5; i++) begin
			bus(1'h0, a[i], 32'h0, rd);
			chk(rd, e[i]);
		end
		bus(1'h1, 32'hc, 32'h8, rd);
		bus(1'h0, 32'hc, 32'h0, rd);
		chk(rd, 32'h8);
		$display("regs end");
	endtask
	task automatic t_ramp;
		logic [7:0] r;
		en <= 1'h1;
		w(3);
		chk(gate, 1'h1);
		w(60);
		r = cur;
		w(28);
		chk(cur, r + 8'h8);
		en <= 1'h0;
		w(2);
		chk(gate, 1'h0);
		en <= 1'h1;
		w(300);
		$display("ramp end");
	endtask
	task automatic t_ph(input int len, input int e);
		int n = 0;
		logic p;
		p = ph;
		repeat (len) begin
			@(posedge hclk);
			if (ph === 1'h1 && p === 1'h0)
				n++;
			p = ph;
		end
		chk(n, e);
		$display("clock end");
	endtask
	// cycles from an external clock rise until the phased output rises
	task automatic lag(output int n);
		@(posedge oscp);
		n = 0;
		while (ph !== 1'h1) begin
			@(posedge hclk);
			n++;
		end
	endtask
	task automatic t_osc;
		int n0, n1;
		tied <= 1'h0;
		bus(1'h1, 32'h4, 32'h14, rd);
		w(60);
		t_ph(280, 14);
		bus(1'h1, 32'h0, 32'h1, rd);
		w(60);
		t_ph(240, 10);
		lag(n0);
		bus(1'h1, 32'h0, 32'h501, rd);
		w(60);
		lag(n1);
		chk(n1 - n0, 5);
		bus(1'h1, 32'h0, 32'h0, rd);
		tied <= 1'h1;
		w(60);
		$display("osc end");
	endtask
	task automatic t_temp;
		tmp <= 2'h1;
		w(4);
		chk({c_oe, g_oe, gate}, 3'h5);
		tmp <= 2'h0;
		w(4);
		chk(g_oe, 1'h0);
		tmp <= 2'h2;
		w(4);
		chk(g_oe, 1'h1);
		tmp <= 2'h0;
		$display("temp end");
	endtask
	task automatic t_open;
		en <= 1'h0;
		w(1);
		en <= 1'h1;
		w(10);
		f <= 6'h01;
		w(4);
		chk({c_oe, g_oe, gate}, 3'h4);
		hold_g <= 1'h1;
		w(4);
		chk(gate, 1'h1);
		hold_g <= 1'h0;
		f <= 6'h0;
		w(300);
		chk(gate, 1'h0);
		w(700);
		chk({g_oe, gate}, 2'h3);
		$display("open end");
	endtask
	task automatic t_uv;
		for (int i = 0; i < 2; i++) begin
			uv <= 4'ha ^ (4'h3 << 2 * i);
			w(4);
			chk({c_oe, g_oe, gate}, 3'h0);
			uv <= 4'ha ^ (4'h2 << 2 * i);
			w(4);
			chk(gate, 1'h0);
			uv <= 4'ha;
			w(4);
			chk(gate, 1'h1);
		end
		$display("uv end");
	endtask
	task automatic t_crit;
		logic [5:0] fv[4] = '{6'h06, 6'h08, 6'h10, 6'h20};
		for (int k = 0; k < 4; k++) begin
			en <= 1'h0;
			w(2);
			en <= 1'h1;
			w(20);
			f <= fv[k];
			w(40);
			chk(c_oe, 1'h1);
			f <= 6'h0;
			w(200);
			if (k == 0) begin
				f <= 6'h02;
				w(6);
				chk({c_oe, g_oe, gate}, 3'h5);
			end
			f <= fv[k];
			w(6);
			chk({c_oe, gate}, 2'h0);
			chk(g_oe, k > 0);
			f <= 6'h0;
			w(10);
			chk(c_oe, 1'h0);
			hold_c <= 1'h1;
			w(4);
			chk(gate, 1'h1);
			hold_c <= 1'h0;
			en <= 1'h0;
			w(SP * 28 + 60);
			chk({slp, c_oe}, 2'h3);
		end
		$display("crit end");
	endtask
	initial begin
		w(5);
		hresetn <= 1'h1;
		w(5);
		t_regs();
		t_ramp();
		t_ph(280, 10);
		t_osc();
		t_temp();
		t_open();
		t_uv();
		t_crit();
		tally_and_finish();
	end
endmodule // tb_top
`default_nettype wire
